/* design/parity_calc.sv */
// Parity bit over the 7 or 8 low bits of a serial word.
// Assumes the word is right aligned, bit 0 first on the line.
`timescale 1ns/1ns
module parity_calc
(
  input  wire logic [8:0] i_word,
  input  wire logic       i_nine_bit,
  input  wire logic       i_odd,
  output logic            o_parity
);

  logic low_xor;

  always_comb
  begin
    low_xor  = i_nine_bit ? ^i_word[7:0] : ^i_word[6:0];
    o_parity = low_xor ^ i_odd; // RULE_07 RULE_08
  end

endmodule

/* design/uart_rx_mute_parity_status.sv */
// Status, mute/wake-up and parity logic of an asynchronous serial port.
// Assumes an external bit-level shifter that hands over whole words and
// frame events, and an APB master for software access.
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ns

// Notes on behaviour
// RULE_01: While muted, no receive flag sets and no receive interrupt is raised.
// RULE_02: Muted receiver wakes on idle line if wake bit clear, address mark if set.
// RULE_03: Idle-line wake clears mute without setting the idle flag.
// RULE_04: Address mark word clears mute, sets receive full, is stored normally.
// RULE_05: Address mark test uses the top data bit, never the parity bit.
// RULE_06: Frames carry 8, 7+parity, 9 or 8+parity bits between start and stop.
// RULE_07: Even parity makes the low data bits plus parity hold even ones.
// RULE_08: Odd parity makes the low data bits plus parity hold odd ones.
// RULE_09: With parity on, transmitted top bit is replaced by computed parity.
// RULE_10: Failed parity check sets parity error; interrupt when parity enable set; the code gates the interrupt by C1_PAR_IRQ.
// RULE_11: Halt freezes transmit and receive; no event leaves halt.
// RULE_12: All events share one interrupt, gated by enables and global mask.
// RULE_13: Status reads C0 after reset: transmit flags set, others clear.
// RULE_14: Transmit empty sets on hand-off to shifter; cleared by status then write.
// RULE_15: Transmit complete sets at frame end, interrupts if enabled, same clear.
// RULE_16: Receive full sets when a word is readable; cleared by status then read.
// RULE_17: Idle flag sets on idle line, only once per receive full.
// RULE_18: Overrun sets when a word completes with receive full still set.
// RULE_19: Noise flag sets with a received word, no interrupt of its own.
// RULE_20: Framing flag sets on bad stop or break; overrun masks it.
// RULE_21: Parity error sits at bit 0; cleared by status read then data access.
// RULE_22: Software must not write control two while muted.
// RULE_23: Receive interrupt enable covers both overrun and receive full.
// RULE_24: Parity enable or select changes apply from the next word.
// RULE_25: A status access arms the clear; a bare data access clears nothing.
module uart_rx_mute_parity_status
  import uart_rx_mute_parity_status_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              i_clock,
  input  wire logic              i_reset_n,
  // APB slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  output logic      [31:0]       o_prdata,
  // Receive side of the bit shifter
  input  wire logic              i_rx_start,
  input  wire logic              i_rx_word_valid,
  input  wire logic [8:0]        i_rx_word,
  input  wire logic              i_rx_noise,
  input  wire logic              i_rx_frame_err,
  input  wire logic              i_rx_idle,
  // Transmit side of the bit shifter, plus its enable and mode controls
  input  wire logic              i_tx_done,
  output logic                   o_tx_start,
  output logic      [8:0]        o_tx_data,
  output logic                   o_tx_nine_bit,
  output logic                   o_send_break,
  output logic                   o_tx_enable,
  output logic                   o_rx_enable,
  output logic                   o_rx_nine_bit,
  output logic                   o_low_power,
  // System
  input  wire logic              i_halt,
  input  wire logic              i_irq_mask,
  output logic                   o_irq,
  output logic                   o_wait_wake
);

  typedef struct packed {
    logic [7:0] control_one;
    logic [7:0] control_two;
    logic [7:0] serial_status;
    logic [7:0] rx_buffer;
    logic [7:0] tx_buffer;
    logic [8:0] tx_data;
    logic       tx_start;
    logic       tx_busy;
    logic       status_seen;
    logic       idle_armed;
    logic       rx_par_en;
    logic       rx_par_odd;
    logic [7:0] rd_data;
  } state_t;

  state_t q;
  state_t d;

  logic [7:0] addr_byte;
  logic       setup;
  logic       access;
  logic       mapped;
  logic       wr_en;
  logic       rd_status;
  logic       wr_data;
  logic       rd_data_acc;
  logic       data_acc;
  logic       rx_nine;
  logic       tx_nine;
  logic [8:0] tx_word;
  logic       tx_par_bit;
  logic       rx_exp_par;
  logic       rx_par_bit;
  logic       rx_msb;
  logic       rx_par_fail;
  logic       muted;
  logic       take_word;
  logic       deliver;
  logic       tx_load;
  logic       irq_rx;
  logic       irq_any;

  // APB decode; every access completes in its first access cycle
  always_comb
  begin
    addr_byte   = 8'(i_paddr);
    setup       = i_psel & ~i_penable;
    access      = i_psel & i_penable;
    mapped      = (addr_byte == ADDR_STATUS) || (addr_byte == ADDR_DATA) ||
                  (addr_byte == ADDR_CONTROL1) || (addr_byte == ADDR_CONTROL2);
    wr_en       = access & i_pwrite & mapped;
    rd_status   = access & (addr_byte == ADDR_STATUS);
    wr_data     = access & i_pwrite & (addr_byte == ADDR_DATA);
    rd_data_acc = access & ~i_pwrite & (addr_byte == ADDR_DATA);
    data_acc    = wr_data | rd_data_acc;
  end

  assign o_pready  = 1'b1;
  assign o_pslverr = access & ~mapped;
  assign o_prdata  = {24'h000000, q.rd_data};

  // Parity for the outgoing word uses the configuration at load time
  assign rx_nine = q.control_one[C1_NINE_BIT];
  assign tx_nine = q.control_one[C1_NINE_BIT];
  assign tx_word = {q.control_one[C1_TX_BIT8], q.tx_buffer};

  parity_calc u_tx_parity
  (
    .i_word     (tx_word),
    .i_nine_bit (tx_nine),
    .i_odd      (q.control_one[C1_PAR_ODD]),
    .o_parity   (tx_par_bit)
  );

  parity_calc u_rx_parity
  (
    .i_word     (i_rx_word),
    .i_nine_bit (rx_nine),
    .i_odd      (q.rx_par_odd),
    .o_parity   (rx_exp_par)
  );

  // Receive word decode
  always_comb
  begin
    rx_par_bit  = rx_nine ? i_rx_word[8] : i_rx_word[7];
    rx_par_fail = q.rx_par_en & (rx_par_bit != rx_exp_par); // RULE_10
    // Address mark: top data bit, skipping the parity position
    if (q.rx_par_en) // RULE_05
    begin
      rx_msb = rx_nine ? i_rx_word[7] : i_rx_word[6];
    end
    else
    begin
      rx_msb = rx_nine ? i_rx_word[8] : i_rx_word[7];
    end
  end

  assign muted     = q.control_two[C2_MUTE];
  assign take_word = i_rx_word_valid & q.control_two[C2_RX_EN] & ~i_halt; // RULE_11
  // Word is delivered when awake or, with the wake bit set, when it carries the address mark
  assign deliver   = take_word &
                     (~muted | (q.control_one[C1_WAKE_ADDR] & rx_msb)); // RULE_01 RULE_04
  assign tx_load   = q.control_two[C2_TX_EN] & ~i_halt & ~q.tx_busy &
                     ~q.serial_status[ST_TX_EMPTY]; // RULE_14

  // Interrupt combination
  always_comb
  begin
    irq_rx  = q.control_two[C2_RX_IRQ] & ~muted & // RULE_01
              (q.serial_status[ST_RX_FULL] | q.serial_status[ST_OVERRUN]); // RULE_23
    irq_any = irq_rx |
              (q.control_two[C2_TX_EMPTY_IRQ] & q.serial_status[ST_TX_EMPTY]) |
              (q.control_two[C2_TX_DONE_IRQ] & q.serial_status[ST_TX_DONE]) |
              (q.control_two[C2_IDLE_IRQ] & q.serial_status[ST_IDLE] & ~muted) |
              (q.control_one[C1_PAR_IRQ] & q.serial_status[ST_PARITY] & ~muted); // RULE_10
  end

  assign o_irq       = irq_any & ~i_irq_mask; // RULE_12
  // Halt is left only by other sources, never by this port
  assign o_wait_wake = irq_any & ~i_irq_mask & ~i_halt; // RULE_11 RULE_12

  assign o_tx_start    = q.tx_start;
  assign o_tx_data     = q.tx_data;
  assign o_tx_nine_bit = tx_nine;
  assign o_rx_nine_bit = rx_nine;
  assign o_send_break  = q.control_two[C2_BREAK];
  assign o_tx_enable   = q.control_two[C2_TX_EN] & ~i_halt;
  assign o_rx_enable   = q.control_two[C2_RX_EN] & ~i_halt;
  assign o_low_power   = q.control_one[C1_LOW_POWER];

  // Next state
  always_comb
  begin
    d          = q;
    d.tx_start = 1'b0;

    // Read data captured in the setup cycle
    if (setup)
    begin
      case (addr_byte)
        ADDR_STATUS:   d.rd_data = q.serial_status;
        ADDR_DATA:     d.rd_data = q.rx_buffer;
        ADDR_CONTROL1: d.rd_data = q.control_one;
        ADDR_CONTROL2: d.rd_data = q.control_two;
        default:       d.rd_data = 8'h00;
      endcase
    end

    // Clear sequence: a data access after a status access
    if (data_acc)
    begin
      d.status_seen = 1'b0; // RULE_25
    end
    if (rd_status)
    begin
      d.status_seen = 1'b1; // RULE_25
    end
    if (rd_data_acc & q.status_seen)
    begin
      d.serial_status = q.serial_status & ~RX_FLAG_MASK; // RULE_16 RULE_21
    end
    if (data_acc & q.status_seen)
    begin
      d.serial_status[ST_PARITY] = 1'b0; // RULE_21
    end
    if (wr_data & q.status_seen)
    begin
      d.serial_status = d.serial_status & ~TX_FLAG_MASK; // RULE_14 RULE_15
    end

    // Software writes
    if (wr_data)
    begin
      d.tx_buffer = i_pwdata[7:0];
    end
    if (wr_en & (addr_byte == ADDR_CONTROL1))
    begin
      d.control_one[6:0] = i_pwdata[6:0];
    end

    // Parity configuration latched at the start of each received word
    if (i_rx_start)
    begin
      d.rx_par_en  = q.control_one[C1_PAR_EN]; // RULE_24
      d.rx_par_odd = q.control_one[C1_PAR_ODD]; // RULE_24
    end

    // Idle frame
    if (i_rx_idle & q.control_two[C2_RX_EN] & ~i_halt)
    begin
      if (muted)
      begin
        if (~q.control_one[C1_WAKE_ADDR])
        begin
          d.control_two[C2_MUTE] = 1'b0; // RULE_02 RULE_03
        end
      end
      else if (q.idle_armed)
      begin
        d.serial_status[ST_IDLE] = 1'b1; // RULE_17
        d.idle_armed             = 1'b0; // RULE_17
      end
    end

    // Completed word
    if (deliver)
    begin
      d.control_two[C2_MUTE] = 1'b0; // RULE_02 RULE_04
      if (q.serial_status[ST_RX_FULL])
      begin
        // Buffer kept; the word in the shifter is lost
        d.serial_status[ST_OVERRUN] = 1'b1; // RULE_18 RULE_20
      end
      else
      begin
        d.rx_buffer                  = i_rx_word[7:0];
        d.control_one[C1_RX_BIT8]    = i_rx_word[8]; // RULE_06
        d.serial_status[ST_RX_FULL]  = 1'b1; // RULE_16 RULE_04
        d.idle_armed                 = 1'b1; // RULE_17
        if (i_rx_noise)
        begin
          d.serial_status[ST_NOISE] = 1'b1; // RULE_19
        end
        if (i_rx_frame_err)
        begin
          d.serial_status[ST_FRAMING] = 1'b1; // RULE_20
        end
        if (rx_par_fail)
        begin
          d.serial_status[ST_PARITY] = 1'b1; // RULE_10
        end
      end
    end

    // Frame finished on the line
    if (i_tx_done & q.tx_busy & ~i_halt)
    begin
      d.tx_busy                   = 1'b0;
      d.serial_status[ST_TX_DONE] = 1'b1; // RULE_15
    end

    // Hand the buffered word to the shifter
    if (tx_load)
    begin
      d.tx_busy  = 1'b1;
      d.tx_start = 1'b1;
      d.tx_data  = tx_word;
      if (q.control_one[C1_PAR_EN])
      begin
        if (tx_nine)
        begin
          d.tx_data[8] = tx_par_bit; // RULE_09
        end
        else
        begin
          d.tx_data[7] = tx_par_bit; // RULE_09
        end
      end
      d.serial_status[ST_TX_EMPTY] = 1'b1; // RULE_14
      d.serial_status[ST_TX_DONE]  = 1'b0;
    end

    // Control two write; overrides a same-cycle hardware wake
    if (wr_en & (addr_byte == ADDR_CONTROL2))
    begin
      d.control_two = i_pwdata[7:0]; // RULE_22
    end

    // Muted receiver: drop any flag set by the word or idle frame
    if (muted & ~deliver)
    begin
      d.serial_status[5:0] = d.serial_status[5:0] & q.serial_status[5:0]; // RULE_01
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      q               <= '0;
      q.serial_status <= STATUS_RESET; // RULE_13
      q.control_one   <= CONTROL1_RESET;
      q.control_two   <= CONTROL2_RESET;
    end
    else
    begin
      q <= d;
    end
  end

endmodule

/* design/uart_rx_mute_parity_status_pkg.sv */
// Register map, field positions and reset values of the serial block.
// Shared by the main module and by the verification side.
package uart_rx_mute_parity_status_pkg;

  // Register byte offsets on APB
  localparam logic [7:0] ADDR_STATUS   = 8'h00;
  localparam logic [7:0] ADDR_DATA     = 8'h04;
  localparam logic [7:0] ADDR_CONTROL1 = 8'h08;
  localparam logic [7:0] ADDR_CONTROL2 = 8'h0C;

  // Reset values
  localparam logic [7:0] STATUS_RESET   = 8'hC0;
  localparam logic [7:0] CONTROL1_RESET = 8'h00;
  localparam logic [7:0] CONTROL2_RESET = 8'h00;

  // serial_status fields
  localparam int ST_TX_EMPTY  = 7;
  localparam int ST_TX_DONE   = 6;
  localparam int ST_RX_FULL   = 5;
  localparam int ST_IDLE      = 4;
  localparam int ST_OVERRUN   = 3;
  localparam int ST_NOISE     = 2;
  localparam int ST_FRAMING   = 1;
  localparam int ST_PARITY    = 0;

  // control_one fields
  localparam int C1_RX_BIT8   = 7;
  localparam int C1_TX_BIT8   = 6;
  localparam int C1_LOW_POWER = 5;
  localparam int C1_NINE_BIT  = 4;
  localparam int C1_WAKE_ADDR = 3;
  localparam int C1_PAR_EN    = 2;
  localparam int C1_PAR_ODD   = 1;
  localparam int C1_PAR_IRQ   = 0;

  // control_two fields
  localparam int C2_TX_EMPTY_IRQ = 7;
  localparam int C2_TX_DONE_IRQ  = 6;
  localparam int C2_RX_IRQ       = 5;
  localparam int C2_IDLE_IRQ     = 4;
  localparam int C2_TX_EN        = 3;
  localparam int C2_RX_EN        = 2;
  localparam int C2_MUTE         = 1;
  localparam int C2_BREAK        = 0;

  // Mask of the receive flags cleared by status access then data read
  localparam logic [7:0] RX_FLAG_MASK = 8'h3F;
  // Mask of the transmit flags cleared by status access then data write
  localparam logic [7:0] TX_FLAG_MASK = 8'hC0;

endpackage

/* tb/serial_node.sv */
// Far-side node model: hands whole words, idles and done pulses to the block.
// Driven by the bench through its tasks; tasks start just after a clock edge.
`timescale 1ns/1ns
module serial_node
#(
  parameter int DONE_CYC = 12
)
(
  input  wire logic       i_clock,
  input  wire logic       i_tx_start,
  input  wire logic [8:0] i_tx_data,
  output logic            o_tx_done,
  output logic            o_rx_start,
  output logic            o_rx_valid,
  output logic      [8:0] o_rx_word,
  output logic            o_rx_noise,
  output logic            o_rx_frame_err,
  output logic            o_rx_idle
);
  logic [8:0] tx_seen = 9'h000;
  int         n_tx = 0;
  int         cnt = 0;

  initial
  begin
    o_rx_start = 1'h0;
    o_rx_valid = 1'h0;
    o_rx_word = 9'h1FF;
    o_rx_noise = 1'h0;
    o_rx_frame_err = 1'h0;
    o_rx_idle = 1'h0;
  end

  // Frame time on the line, then a one-cycle done pulse
  always @(posedge i_clock)
  begin
    o_tx_done <= 1'h0;
    if (i_tx_start)
    begin
      tx_seen <= i_tx_data;
      n_tx <= n_tx + 1;
      cnt <= DONE_CYC;
    end
    else if (cnt == 1)
    begin
      o_tx_done <= 1'h1;
      cnt <= 0;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
  end

  task automatic rx_frame(input logic [8:0] w, input logic nz, input logic fe);
    o_rx_start <= 1'h1;
    @(posedge i_clock);
    o_rx_start <= 1'h0;
    repeat (3) @(posedge i_clock);
    o_rx_valid <= 1'h1;
    o_rx_word <= w;
    o_rx_noise <= nz;
    o_rx_frame_err <= fe;
    @(posedge i_clock);
    o_rx_valid <= 1'h0;
    o_rx_word <= ~w;
    o_rx_noise <= ~nz;
    o_rx_frame_err <= ~fe;
  endtask

  task automatic idle_frame();
    o_rx_idle <= 1'h1;
    @(posedge i_clock);
    o_rx_idle <= 1'h0;
  endtask
endmodule

/* tb/tb.sv */
// Self-checking bench: APB tasks reach the registers, the node model
// supplies words, idles and done pulses on the far side.
`timescale 1ns/1ns
module tb
  import uart_rx_mute_parity_status_pkg::*;
;
  logic        i_clock, i_reset_n, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
  logic [7:0]  i_paddr, q;
  logic [31:0] i_pwdata, o_prdata;
  logic        i_rx_start, i_rx_word_valid, i_rx_noise, i_rx_frame_err, i_rx_idle;
  logic [8:0]  i_rx_word, o_tx_data;
  logic        i_tx_done, o_tx_start, o_tx_nine_bit, o_send_break, o_tx_enable;
  logic        o_rx_enable, o_rx_nine_bit, o_low_power, i_halt, i_irq_mask;
  logic        o_irq, o_wait_wake, e, p;
  int          fail_count = 0;
  int          n_checks = 0;

  uart_rx_mute_parity_status u_uart_rx_mute_parity_status (.*);
  serial_node u_serial_node (.i_clock(i_clock), .i_tx_start(o_tx_start),
    .i_tx_data(o_tx_data), .o_tx_done(i_tx_done), .o_rx_start(i_rx_start),
    .o_rx_valid(i_rx_word_valid), .o_rx_word(i_rx_word), .o_rx_noise(i_rx_noise),
    .o_rx_frame_err(i_rx_frame_err), .o_rx_idle(i_rx_idle));

  initial
  begin
    i_clock = 1'h0;
    forever #50 i_clock = ~i_clock;
  end

  task automatic chk(input string nm, input logic [8:0] x, input logic [8:0] got);
    n_checks++;
    if (got !== x)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, x, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    i_psel <= 1'h1;
    i_penable <= 1'h0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= {24'h0, d};
    @(posedge i_clock);
    i_penable <= 1'h1;
    @(posedge i_clock);
    while (o_pready !== 1'h1) @(posedge i_clock);
    q = o_prdata[7:0];
    e = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
    @(posedge i_clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x, input string nm);
    apb(1'h0, a, 8'h00);
    chk(nm, {1'h0, x}, {1'h0, q});
  endtask

  task automatic irq_is(input logic x);
    @(negedge i_clock);
    chk("irq", {8'h00, x}, {8'h00, o_irq});
    @(posedge i_clock);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge i_clock);
    fail_count++;
    $display("[ERR] watchdog expected finish seen hang");
    summarize();
  end

  initial
  begin
    i_reset_n = 1'h0;
    i_psel = 1'h0;
    i_penable = 1'h0;
    i_pwrite = 1'h0;
    i_paddr = 8'h00;
    i_pwdata = 32'h0;
    i_halt = 1'h0;
    i_irq_mask = 1'h0;
    repeat (4) @(posedge i_clock);
    i_reset_n <= 1'h1;
    @(posedge i_clock);
    rd(ADDR_STATUS, STATUS_RESET, "status");
    rd(ADDR_CONTROL2, CONTROL2_RESET, "ctl2");
    rd(8'h10, 8'h00, "unmapped");
    chk("slverr", 9'h001, {8'h00, e});
    apb(1'h0, ADDR_DATA, 8'h00);
    $display("test reset done");
    // Receive, unarmed read, error flags, overrun
    apb(1'h1, ADDR_CONTROL2, 8'h24);
    u_serial_node.rx_frame(9'h05A, 1'h1, 1'h1);
    apb(1'h0, ADDR_DATA, 8'h00);
    rd(ADDR_STATUS, 8'hE6, "status");
    irq_is(1'h1);
    i_irq_mask <= 1'h1;
    irq_is(1'h0);
    i_irq_mask <= 1'h0;
    u_serial_node.rx_frame(9'h033, 1'h0, 1'h1);
    rd(ADDR_STATUS, 8'hEE, "status");
    rd(ADDR_DATA, 8'h5A, "data");
    rd(ADDR_STATUS, 8'hC0, "status");
    irq_is(1'h0);
    $display("test receive done");
    apb(1'h1, ADDR_CONTROL2, 8'h04);
    for (int k = 0; k < 4; k++)
    begin
      apb(1'h1, ADDR_CONTROL1, {5'h00, 1'h1, k[1], 1'h1});
      p = (^7'h35) ^ k[1] ^ k[0];
      u_serial_node.rx_frame({1'h0, p, 7'h35}, 1'h0, 1'h0);
      irq_is(k[0]);
      rd(ADDR_STATUS, {7'h70, k[0]}, "status");
      apb(1'h0, ADDR_DATA, 8'h00);
    end
    apb(1'h1, ADDR_CONTROL1, 8'h34);
    chk("ctl1_pins", 9'h007, {6'h00, o_low_power, o_rx_nine_bit, o_tx_nine_bit});
    u_serial_node.rx_frame(9'h135, 1'h0, 1'h0);
    rd(ADDR_CONTROL1, 8'hB4, "ctl1");
    rd(ADDR_STATUS, 8'hE1, "status");
    rd(ADDR_DATA, 8'h35, "data");
    fork
      u_serial_node.rx_frame(9'h135, 1'h0, 1'h0);
      apb(1'h1, ADDR_CONTROL1, 8'h10);
    join
    rd(ADDR_STATUS, 8'hE1, "status");
    rd(ADDR_DATA, 8'h35, "data");
    $display("test parity done");
    apb(1'h1, ADDR_CONTROL1, 8'h0C);
    apb(1'h1, ADDR_CONTROL2, 8'h26);
    u_serial_node.rx_frame(9'h080, 1'h0, 1'h1);
    rd(ADDR_STATUS, 8'hC0, "status");
    irq_is(1'h0);
    u_serial_node.rx_frame(9'h0C0, 1'h0, 1'h0);
    rd(ADDR_CONTROL2, 8'h24, "ctl2");
    rd(ADDR_STATUS, 8'hE0, "status");
    irq_is(1'h1);
    apb(1'h1, ADDR_CONTROL1, 8'h00);
    apb(1'h1, ADDR_CONTROL2, 8'h26);
    irq_is(1'h0);
    apb(1'h0, ADDR_DATA, 8'h00);
    u_serial_node.rx_frame(9'h011, 1'h0, 1'h0);
    rd(ADDR_STATUS, 8'hC0, "status");
    u_serial_node.idle_frame();
    rd(ADDR_CONTROL2, 8'h24, "ctl2");
    rd(ADDR_STATUS, 8'hC0, "status");
    u_serial_node.rx_frame(9'h022, 1'h0, 1'h0);
    apb(1'h0, ADDR_STATUS, 8'h00);
    apb(1'h0, ADDR_DATA, 8'h00);
    u_serial_node.idle_frame();
    rd(ADDR_STATUS, 8'hD0, "status");
    apb(1'h0, ADDR_DATA, 8'h00);
    u_serial_node.idle_frame();
    rd(ADDR_STATUS, 8'hC0, "status");
    $display("test mute done");
    apb(1'h1, ADDR_CONTROL2, 8'h08);
    apb(1'h0, ADDR_DATA, 8'h00);
    apb(1'h1, ADDR_DATA, 8'hB5);
    repeat (4) @(posedge i_clock);
    chk("loads", 9'h000, 9'(u_serial_node.n_tx));
    for (int k = 0; k < 2; k++)
    begin
      apb(1'h1, ADDR_CONTROL1, {5'h00, 1'h1, k[0], 1'h0});
      rd(ADDR_STATUS, 8'hC0, "status");
      apb(1'h1, ADDR_DATA, 8'hB5);
      while (u_serial_node.n_tx != k + 1) @(posedge i_clock);
      rd(ADDR_STATUS, 8'h80, "status");
      chk("tx_word", {1'h0, k[0], 7'h35}, u_serial_node.tx_seen);
      while (u_serial_node.cnt != 0) @(posedge i_clock);
      @(posedge i_clock);
    end
    rd(ADDR_STATUS, 8'hC0, "status");
    $display("test transmit done");
    apb(1'h1, ADDR_CONTROL2, 8'h25);
    chk("break_rx_en", 9'h003, {7'h00, o_send_break, o_rx_enable});
    i_halt <= 1'h1;
    u_serial_node.rx_frame(9'h055, 1'h0, 1'h0);
    u_serial_node.idle_frame();
    i_halt <= 1'h0;
    irq_is(1'h0);
    rd(ADDR_STATUS, 8'hC0, "status");
    $display("test halt done");
    summarize();
  end
endmodule

/* tb/uart_rx_mute_parity_status_chk.sv */
// Port assertions for the serial status block, bound to it.
// Sees top ports only; mirrors control_two from APB writes.
`timescale 1ns/1ns
module uart_status_chk
  import uart_rx_mute_parity_status_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic              i_clock,
  input wire logic              i_reset_n,
  input wire logic              i_psel,
  input wire logic              i_penable,
  input wire logic              i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0]       i_pwdata,
  input wire logic              i_rx_word_valid,
  input wire logic              i_tx_done,
  input wire logic              i_halt,
  input wire logic              i_irq_mask,
  input wire logic              o_pslverr,
  input wire logic              o_tx_start,
  input wire logic [8:0]        o_tx_data,
  input wire logic              o_tx_enable,
  input wire logic              o_rx_enable,
  input wire logic              o_irq,
  input wire logic              o_wait_wake
);
  logic       busy_q;
  logic [7:0] ctl2_q;
  logic       rx_irq_on;

  default clocking @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);

  // Mirror stays muted after a wake, so only a clear mirror is trusted
  assign rx_irq_on = ctl2_q[C2_RX_IRQ] && ctl2_q[C2_RX_EN] && !ctl2_q[C2_MUTE];

  // Load outstanding until the shifter reports done
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      busy_q <= 1'h0;
      ctl2_q <= 8'h00;
    end
    else
    begin
      if (o_tx_start)
        busy_q <= 1'h1;
      else if (i_tx_done)
        busy_q <= 1'h0;
      if (i_psel && i_penable && i_pwrite && i_paddr == ADDR_W'(ADDR_CONTROL2))
        ctl2_q <= i_pwdata[7:0];
    end
  end

  a_mask_blocks_irq: assert property (i_irq_mask |-> !o_irq)
    else $error("interrupt raised while masked");
  a_wait_wake_follows: assert property (o_wait_wake == (o_irq && !i_halt))
    else $error("wait wake does not follow interrupt");
  a_halt_stops_load: assert property (i_halt |=> !o_tx_start)
    else $error("load started during halt");
  a_halt_gates_enables: assert property (i_halt |-> !o_tx_enable && !o_rx_enable)
    else $error("enable high during halt");
  a_tx_single_pulse: assert property (o_tx_start |=> !o_tx_start)
    else $error("load pulse longer than one cycle");
  a_tx_one_load: assert property (o_tx_start |-> !busy_q)
    else $error("load before previous frame done");
  a_tx_data_hold: assert property ($changed(o_tx_data) |-> o_tx_start)
    else $error("transmit word changed without load");
  a_rx_irq_raise: assert property ((i_rx_word_valid && rx_irq_on && !i_halt) ##1 !i_irq_mask |-> o_irq)
    else $error("no interrupt after received word");

  c_tx_load: cover property (o_tx_start);
  c_irq_out: cover property (o_irq && !i_irq_mask);
  c_bad_addr: cover property (o_pslverr);
endmodule

bind uart_rx_mute_parity_status uart_status_chk #(.ADDR_W(ADDR_W)) u_uart_status_chk (.*);
